//--- rtl/regulator_voltage_monitor.v
// Voltage supervisor for seven buck and four linear regulator outputs
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "vmon_regs.vh"
module regulator_voltage_monitor #(
  // Undervoltage debounce lengths in cycles
  parameter [15:0] UNDERVOLTAGE_DEBOUNCE_SELECT_CYC0 = `UV_DB0_US * `CLK_MHZ,
  parameter [15:0] UNDERVOLTAGE_DEBOUNCE_SELECT_CYC1 = `UV_DB1_US * `CLK_MHZ,
  parameter [15:0] UNDERVOLTAGE_DEBOUNCE_SELECT_CYC2 = `UV_DB2_US * `CLK_MHZ,
  parameter [15:0] UNDERVOLTAGE_DEBOUNCE_SELECT_CYC3 = `UV_DB3_US * `CLK_MHZ,
  // Overvoltage debounce lengths in cycles
  parameter [15:0] OVERVOLTAGE_DEBOUNCE_SELECT_CYC0 = `OV_DB0_US * `CLK_MHZ,
  parameter [15:0] OVERVOLTAGE_DEBOUNCE_SELECT_CYC1 = `OV_DB1_US * `CLK_MHZ,
  parameter [15:0] OVERVOLTAGE_DEBOUNCE_SELECT_CYC2 = `OV_DB2_US * `CLK_MHZ,
  parameter [15:0] OVERVOLTAGE_DEBOUNCE_SELECT_CYC3 = `OV_DB3_US * `CLK_MHZ,
  // Settling mask after enabling, in cycles
  parameter [15:0] SETTLE_CYC = `SETTLE_US * `CLK_MHZ
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Interrupt
  output reg irq,
  // Analog comparator results, asynchronous
  input wire [10:0] undervoltageComp,
  input wire [10:0] overvoltageComp,
  input wire [10:0] regulationReached,
  // Regulator on state from the sequencer
  input wire [10:0] regulatorOn,
  // Nonvolatile threshold codes
  input wire [13:0] nvSwitcherUvCode,
  input wire [7:0] nvLinearUvCode,
  input wire [13:0] nvSwitcherOvCode,
  input wire [7:0] nvLinearOvCode,
  // Threshold codes to the comparators
  output reg [13:0] switcherUndervoltageLevelCode,
  output reg [7:0] linearUndervoltageLevelCode,
  output reg [13:0] switcherOvervoltageLevelCode,
  output reg [7:0] linearOvervoltageLevelCode,
  // Debounced status
  output reg [10:0] undervoltageStatus,
  output reg [10:0] overvoltageStatus
);

  // Picks one of four debounce lengths
  function [15:0] dbLimit;
    input [1:0] sel;
    input [15:0] t0;
    input [15:0] t1;
    input [15:0] t2;
    input [15:0] t3;
    begin
      case (sel)
        2'h0: dbLimit = t0;
        2'h1: dbLimit = t1;
        2'h2: dbLimit = t2;
        default: dbLimit = t3;
      endcase
    end
  endfunction

  // Byte-lane merge of a write
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer b;
    begin
      laneMerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          laneMerge[b*8 +: 8] = din[b*8 +: 8];
        end
      end
    end
  endfunction

  // Synchroniser stages
  reg [10:0] uvMeta_ff; // First stage, read only by second
  reg [10:0] uvSync_ff; // Second stage
  reg [10:0] ovMeta_ff; // First stage
  reg [10:0] ovSync_ff; // Second stage
  reg [10:0] regMeta_ff; // First stage
  reg [10:0] regSync_ff; // Second stage

  // Software state
  reg [1:0] uvDbSel_ff; // Undervoltage debounce select
  reg [1:0] ovDbSel_ff; // Overvoltage debounce select
  reg secureEn_ff; // Secure write mode
  reg unlocked_ff; // Unlock armed for next write
  reg [10:0] monEn_ff; // Per-channel supervision enable
  reg [21:0] irqStat_ff; // Sticky events
  reg [21:0] irqEn_ff; // Event enables
  reg codesLoaded_ff; // Threshold codes captured

  // Settling mask state
  reg [15:0] settleCnt_ff [0:10]; // Cycles since channel armed
  reg [10:0] settled_ff; // Settling period over

  // Combinational terms
  wire [15:0] uvLimit; // Selected undervoltage length
  wire [15:0] ovLimit; // Selected overvoltage length
  wire [10:0] armed; // Enabled and regulator on
  wire [10:0] active; // Comparators honoured
  wire [10:0] uvDone; // Undervoltage persisted
  wire [10:0] ovDone; // Overvoltage persisted
  wire [10:0] nxt_uvStatus; // Next undervoltage status
  wire [10:0] nxt_ovStatus; // Next overvoltage status
  wire [21:0] events; // New status rises
  wire busReq; // Request without answer yet
  wire wrTake; // Write taking effect
  wire [31:0] clrMask; // Write-one-to-clear mask
  wire [31:0] monEnMerged; // Enables after lane merge
  wire [31:0] irqEnMerged; // Event enables after lane merge
  reg [21:0] nxt_irqStat; // Next sticky events
  reg [31:0] nxt_rdData; // Read mux

  // Debounce lengths from the shared selects
  assign uvLimit = dbLimit(uvDbSel_ff, UNDERVOLTAGE_DEBOUNCE_SELECT_CYC0, UNDERVOLTAGE_DEBOUNCE_SELECT_CYC1,
                           UNDERVOLTAGE_DEBOUNCE_SELECT_CYC2, UNDERVOLTAGE_DEBOUNCE_SELECT_CYC3);
  assign ovLimit = dbLimit(ovDbSel_ff, OVERVOLTAGE_DEBOUNCE_SELECT_CYC0, OVERVOLTAGE_DEBOUNCE_SELECT_CYC1,
                           OVERVOLTAGE_DEBOUNCE_SELECT_CYC2, OVERVOLTAGE_DEBOUNCE_SELECT_CYC3);

  // Channel gating: enable, regulator on, regulated, settled
  assign armed = monEn_ff & regulatorOn;
  assign active = armed & regSync_ff & settled_ff;

  // Bus request decode
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrTake = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

  // Lane-merged write values, cut to register width where used
  assign clrMask = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign monEnMerged = laneMerge({21'h00_0000, monEn_ff}, wb_dat_i, wb_sel_i);
  assign irqEnMerged = laneMerge({10'h000, irqEn_ff}, wb_dat_i, wb_sel_i);

  // Two-stage synchronisers on analog inputs
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uvMeta_ff <= 11'h000;
      uvSync_ff <= 11'h000;
      ovMeta_ff <= 11'h000;
      ovSync_ff <= 11'h000;
      regMeta_ff <= 11'h000;
      regSync_ff <= 11'h000;
    end else begin
      uvMeta_ff <= undervoltageComp;
      uvSync_ff <= uvMeta_ff;
      ovMeta_ff <= overvoltageComp;
      ovSync_ff <= ovMeta_ff;
      regMeta_ff <= regulationReached;
      regSync_ff <= regMeta_ff;
    end
  end

  // Capture threshold codes once after reset release
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      codesLoaded_ff <= 1'b0;
      switcherUndervoltageLevelCode <= 14'h0000;
      linearUndervoltageLevelCode <= 8'h00;
      switcherOvervoltageLevelCode <= 14'h0000;
      linearOvervoltageLevelCode <= 8'h00;
    end else if (!codesLoaded_ff) begin
      // Codes pass unchanged to the comparators
      codesLoaded_ff <= 1'b1;
      switcherUndervoltageLevelCode <= nvSwitcherUvCode;
      linearUndervoltageLevelCode <= nvLinearUvCode;
      switcherOvervoltageLevelCode <= nvSwitcherOvCode;
      linearOvervoltageLevelCode <= nvLinearOvCode;
    end
  end

  // Settling counters, one per channel
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : gSettle
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          settleCnt_ff[g] <= 16'h0000;
          settled_ff[g] <= 1'b0;
        end else if (!armed[g]) begin
          // Disabled or off: restart the mask
          settleCnt_ff[g] <= 16'h0000;
          settled_ff[g] <= 1'b0;
        end else if (settleCnt_ff[g] >= SETTLE_CYC - 16'h0001) begin
          // Mask ends after the settling period
          settled_ff[g] <= 1'b1;
        end else begin
          settleCnt_ff[g] <= settleCnt_ff[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // Persistence timers, one pair per channel
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : gChan
      // Undervoltage persistence
      persist_timer uUvTimer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cond(active[g] & uvSync_ff[g]),
        .limit(uvLimit),
        .done(uvDone[g])
      );
      // Overvoltage persistence
      persist_timer uOvTimer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cond(active[g] & ovSync_ff[g]),
        .limit(ovLimit),
        .done(ovDone[g])
      );
    end
  endgenerate

  // Status follows persisted faults, zero when disabled
  assign nxt_uvStatus = uvDone & active & monEn_ff;
  assign nxt_ovStatus = ovDone & active & monEn_ff;
  assign events = {nxt_ovStatus & ~overvoltageStatus,
                   nxt_uvStatus & ~undervoltageStatus};

  // Status registers
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      undervoltageStatus <= 11'h000;
      overvoltageStatus <= 11'h000;
    end else begin
      undervoltageStatus <= nxt_uvStatus;
      overvoltageStatus <= nxt_ovStatus;
    end
  end

  // Sticky events: a new event beats a clear in the same cycle
  always @* begin
    nxt_irqStat = irqStat_ff;
    if (wrTake && wb_adr_i == `OFS_IRQ_CLR) begin
      // Write one to clear
      nxt_irqStat = irqStat_ff & ~clrMask[21:0];
    end
    nxt_irqStat = nxt_irqStat | events;
  end

  // Interrupt state
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_ff <= 22'h00_0000;
      irq <= 1'b0;
    end else begin
      irqStat_ff <= nxt_irqStat;
      irq <= |(nxt_irqStat & irqEn_ff);
    end
  end

  // Software writes to control, enables and unlock
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uvDbSel_ff <= `RST_UVDB;
      ovDbSel_ff <= `RST_OVDB;
      secureEn_ff <= `RST_SECURE;
      monEn_ff <= `RST_MON_EN;
      irqEn_ff <= `RST_IRQ_EN;
      unlocked_ff <= 1'b0;
    end else if (wrTake) begin
      // Any write uses up an armed unlock
      unlocked_ff <= 1'b0;
      case (wb_adr_i)
        `OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            uvDbSel_ff <= wb_dat_i[`CTRL_UVDB_LSB +: 2];
            ovDbSel_ff <= wb_dat_i[`CTRL_OVDB_LSB +: 2];
            secureEn_ff <= wb_dat_i[`CTRL_SECURE_BIT];
          end
        end
        `OFS_MON_EN: begin
          // Secure mode: only an unlocked write changes enables
          if (!secureEn_ff || unlocked_ff) begin
            monEn_ff <= monEnMerged[10:0];
          end
        end
        `OFS_UNLOCK: begin
          // Key arms exactly the next write
          if (wb_sel_i == 4'hF && wb_dat_i == `UNLOCK_KEY) begin
            unlocked_ff <= 1'b1;
          end
        end
        `OFS_IRQ_EN: begin
          irqEn_ff <= irqEnMerged[21:0];
        end
        default: begin
          // Clear register, read-only or unmapped: ignored here
          unlocked_ff <= 1'b0;
        end
      endcase
    end
  end

  // Read data mux
  always @* begin
    nxt_rdData = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_CTRL: begin
        nxt_rdData[`CTRL_UVDB_LSB +: 2] = uvDbSel_ff;
        nxt_rdData[`CTRL_OVDB_LSB +: 2] = ovDbSel_ff;
        nxt_rdData[`CTRL_SECURE_BIT] = secureEn_ff;
      end
      `OFS_MON_EN: begin
        nxt_rdData[10:0] = monEn_ff;
      end
      `OFS_UNLOCK: begin
        nxt_rdData[0] = unlocked_ff;
      end
      `OFS_UV_STAT: begin
        nxt_rdData[10:0] = undervoltageStatus;
      end
      `OFS_OV_STAT: begin
        nxt_rdData[10:0] = overvoltageStatus;
      end
      `OFS_IRQ_STAT: begin
        nxt_rdData[21:0] = irqStat_ff;
      end
      `OFS_IRQ_EN: begin
        nxt_rdData[21:0] = irqEn_ff;
      end
      `OFS_UV_CODE: begin
        nxt_rdData[21:0] = {linearUndervoltageLevelCode,
                            switcherUndervoltageLevelCode};
      end
      `OFS_OV_CODE: begin
        nxt_rdData[21:0] = {linearOvervoltageLevelCode,
                            switcherOvervoltageLevelCode};
      end
      default: begin
        // Clear register and unmapped read as zero
        nxt_rdData = 32'h0000_0000;
      end
    endcase
  end

  // Bus answer: ack one cycle after request, dropped the next
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq) begin
      wb_ack_o <= 1'b1;
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : nxt_rdData;
    end else begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule // regulator_voltage_monitor

//--- rtl/vmon_regs.vh
// Register map, field layout, reset values and timing figures of the voltage monitor
`ifndef VMON_REGS_VH
`define VMON_REGS_VH

// Channel counts
`define NUM_SW 7
`define NUM_LDO 4
`define NUM_CH 11

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_MON_EN 8'h04
`define OFS_UNLOCK 8'h08
`define OFS_UV_STAT 8'h0C
`define OFS_OV_STAT 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_CLR 8'h18
`define OFS_IRQ_EN 8'h1C
`define OFS_UV_CODE 8'h20
`define OFS_OV_CODE 8'h24

// Control register fields
`define CTRL_UVDB_LSB 0
`define CTRL_OVDB_LSB 2
`define CTRL_SECURE_BIT 4

// Reset values
`define RST_UVDB 2'h2
`define RST_OVDB 2'h0
`define RST_SECURE 1'h0
`define RST_MON_EN 11'h7FF
`define RST_IRQ_EN 22'h00_0000

// Unlock key for a secure write (arbitrary value)
`define UNLOCK_KEY 32'h0000_5AC3

// Clock rate and times in microseconds
`define CLK_MHZ 200
`define UV_DB0_US 5
`define UV_DB1_US 15
`define UV_DB2_US 25
`define UV_DB3_US 40
`define OV_DB0_US 25
`define OV_DB1_US 50
`define OV_DB2_US 80
`define OV_DB3_US 125
`define SETTLE_US 30

`endif

//--- rtl/persist_timer.v
// Persistence timer: flags a condition that has held for a whole limit of cycles
`timescale 1ns/10ps
module persist_timer (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Condition and length
  input wire cond,
  input wire [15:0] limit,
  // Result
  output reg done
);

  reg [15:0] cnt_ff; // Cycles the condition has held

  // Count while held, restart on any break
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 16'h0000;
      done <= 1'b0;
    end else if (!cond) begin
      // Break restarts the timer
      cnt_ff <= 16'h0000;
      done <= 1'b0;
    end else if (cnt_ff >= limit - 16'h0001) begin
      // Full length reached
      done <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

endmodule // persist_timer

//--- dv/vmon_comparators.sv
// Behavioural model of the analog comparators beside each regulator
`timescale 1ns/10ps
module vmon_comparators (
  // Regulator state and test controls
  input wire [10:0] regulatorOn,
  input wire [10:0] lowFault,
  input wire [10:0] highFault,
  input wire [10:0] atLevel,
  // Comparator results
  output wire [10:0] undervoltageComp,
  output wire [10:0] overvoltageComp,
  output wire [10:0] regulationReached
);
  // An off regulator sits below every undervoltage level
  assign undervoltageComp = ~regulatorOn | lowFault;
  // Only a running regulator can overshoot
  assign overvoltageComp = regulatorOn & highFault;
  // Regulation is reached once the ramp has ended
  assign regulationReached = regulatorOn & atLevel;
endmodule // vmon_comparators

//--- dv/vmon_monitor.sv
// Checker of bus handshake, interrupt line and status masking
`timescale 1ns/10ps
module vmon_monitor (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Monitor side
  input wire irq,
  input wire [10:0] regulatorOn,
  input wire [10:0] undervoltageStatus,
  input wire [10:0] overvoltageStatus
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Off history per regulator
  logic [10:0] off1_ff;
  logic [10:0] off2_ff;
  logic [10:0] off3_ff;
  // Recent acks and status activity
  logic [2:0] ackHist_ff;
  logic statHist_ff;
  // Shift the histories every cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      off1_ff <= 11'h000;
      off2_ff <= 11'h000;
      off3_ff <= 11'h000;
      ackHist_ff <= 3'h0;
      statHist_ff <= 1'b0;
    end else begin
      off1_ff <= ~regulatorOn;
      off2_ff <= off1_ff;
      off3_ff <= off2_ff;
      ackHist_ff <= {ackHist_ff[1:0], wb_ack_o};
      statHist_ff <= |{undervoltageStatus, overvoltageStatus};
    end
  end
  ack_after_req_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a:
    assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero while idle");
  uv_off_clear_a:
    assert property ((undervoltageStatus & ~regulatorOn & off1_ff & off2_ff & off3_ff) == 11'h000)
    else $error("undervoltage status on a switched off regulator");
  ov_off_clear_a:
    assert property ((overvoltageStatus & ~regulatorOn & off1_ff & off2_ff & off3_ff) == 11'h000)
    else $error("overvoltage status on a switched off regulator");
  irq_rise_a:
    assert property ($rose(irq) |-> statHist_ff || (|{undervoltageStatus, overvoltageStatus}) || ackHist_ff != 3'h0)
    else $error("irq rose without event or write");
  irq_fall_a:
    assert property ($fell(irq) |-> ackHist_ff != 3'h0)
    else $error("irq fell without a write");
endmodule // vmon_monitor
bind regulator_voltage_monitor vmon_monitor vmon_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq(irq), .regulatorOn(regulatorOn), .undervoltageStatus(undervoltageStatus),
  .overvoltageStatus(overvoltageStatus));

//--- dv/tb_top.sv
// Self-checking bench of the regulator voltage monitor
`timescale 1ns/10ps
`include "vmon_regs.vh"
module tb_top;
  // Clock, reset and bus
  logic core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdData;
  // Regulator side
  logic [10:0] uvComp, ovComp, regOk, regulatorOn, lowFault, highFault, atLevel, uvStat, ovStat;
  logic [13:0] swUvOut, swOvOut;
  logic [7:0] lnUvOut, lnOvOut;
  // Debounce lengths handed to the design
  int uvLen[4] = '{4, 10, 16, 22};
  int ovLen[4] = '{6, 12, 18, 26};
  int failures, comparisons;
  // Fixed nonvolatile codes and settling length
  localparam logic [13:0] SW_UV = 14'h1B4E;
  localparam logic [7:0] LN_UV = 8'h93;
  localparam logic [13:0] SW_OV = 14'h24B1;
  localparam logic [7:0] LN_OV = 8'h6C;
  localparam int SETTLE = 30;
  logic [13:0] nvSwUv, nvSwOv;
  logic [7:0] nvLnUv, nvLnOv;
  regulator_voltage_monitor #(.UNDERVOLTAGE_DEBOUNCE_SELECT_CYC0(16'h0004), .UNDERVOLTAGE_DEBOUNCE_SELECT_CYC1(16'h000A),
    .UNDERVOLTAGE_DEBOUNCE_SELECT_CYC2(16'h0010), .UNDERVOLTAGE_DEBOUNCE_SELECT_CYC3(16'h0016), .OVERVOLTAGE_DEBOUNCE_SELECT_CYC0(16'h0006),
    .OVERVOLTAGE_DEBOUNCE_SELECT_CYC1(16'h000C), .OVERVOLTAGE_DEBOUNCE_SELECT_CYC2(16'h0012), .OVERVOLTAGE_DEBOUNCE_SELECT_CYC3(16'h001A),
    .SETTLE_CYC(16'h001E)) regulator_voltage_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq), .undervoltageComp(uvComp), .overvoltageComp(ovComp),
    .regulationReached(regOk), .regulatorOn(regulatorOn), .nvSwitcherUvCode(nvSwUv),
    .nvLinearUvCode(nvLnUv), .nvSwitcherOvCode(nvSwOv), .nvLinearOvCode(nvLnOv),
    .switcherUndervoltageLevelCode(swUvOut), .linearUndervoltageLevelCode(lnUvOut),
    .switcherOvervoltageLevelCode(swOvOut), .linearOvervoltageLevelCode(lnOvOut),
    .undervoltageStatus(uvStat), .overvoltageStatus(ovStat));
  vmon_comparators vmon_comparators_i (.regulatorOn(regulatorOn), .lowFault(lowFault),
    .highFault(highFault), .atLevel(atLevel), .undervoltageComp(uvComp),
    .overvoltageComp(ovComp), .regulationReached(regOk));
  // Free running clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Compare a value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare a cycle count against a span
  task automatic chkSpan(input string what, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // One classic cycle; read data lands in rdData
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    rdData = wb_dat_o;
    if (n >= 50) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  // Raise a fault, count cycles to its status, optionally drop it again
  task automatic trip(input bit ov, input int ch, input int lo, input int hi, input bit keep);
    int k;
    k = 0;
    {highFault[ch], lowFault[ch]} <= ov ? 2'b10 : 2'b01;
    @(posedge core_clk);
    while ((ov ? ovStat[ch] : uvStat[ch]) !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    chkSpan("trip cycles", lo, hi, k);
    if (!keep) begin
      {highFault[ch], lowFault[ch]} <= 2'b00;
      repeat (6) @(posedge core_clk);
      chk("status release", 32'h0, 32'({ovStat[ch], uvStat[ch]}));
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {failures, comparisons} = 0;
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 0;
    {regulatorOn, lowFault, highFault, atLevel} = 0;
    wb_sel_i = 4'hF;
    {nvSwUv, nvLnUv, nvSwOv, nvLnOv} = {SW_UV, LN_UV, SW_OV, LN_OV};
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("uv codes", 32'({LN_UV, SW_UV}), 32'({lnUvOut, swUvOut}));
    chk("ov codes", 32'({LN_OV, SW_OV}), 32'({lnOvOut, swOvOut}));
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0002, rdData);
    bus(1'b0, `OFS_MON_EN, 32'h0);
    chk("enable reset", 32'h0000_07FF, rdData);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rdData);
    // Regulators on but still ramping: faults stay masked
    regulatorOn <= 11'h7FF;
    lowFault <= 11'h7FF;
    repeat (60) @(posedge core_clk);
    chk("ramp masked", 32'h0, 32'({ovStat, uvStat}));
    lowFault <= 11'h000;
    atLevel <= 11'h7FF;
    repeat (SETTLE + 5) @(posedge core_clk);
    // Every debounce select, buck and linear channels
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `OFS_CTRL, 32'(s * 5));
      trip(1'b0, s, uvLen[s] + 1, uvLen[s] + 6, 1'b0);
      trip(1'b1, s + 7, ovLen[s] + 1, ovLen[s] + 6, 1'b0);
    end
    // A one cycle break restarts the count
    bus(1'b1, `OFS_CTRL, 32'h0000_0002);
    lowFault[5] <= 1'b1;
    repeat (10) @(posedge core_clk);
    lowFault[5] <= 1'b0;
    @(posedge core_clk);
    trip(1'b0, 5, 17, 22, 1'b0);
    // Disabling a channel forces its status low
    trip(1'b0, 0, 17, 22, 1'b1);
    bus(1'b1, `OFS_MON_EN, 32'h0000_07FE);
    repeat (40) @(posedge core_clk);
    chk("disabled status", 32'h0, 32'(uvStat[0]));
    lowFault[0] <= 1'b0;
    bus(1'b1, `OFS_MON_EN, 32'h0000_07F7);
    bus(1'b1, `OFS_MON_EN, 32'h0000_07FF);
    trip(1'b0, 3, SETTLE, SETTLE + 30, 1'b0);
    // Secure mode needs the unlock key
    bus(1'b1, `OFS_CTRL, 32'h0000_0012);
    bus(1'b1, `OFS_MON_EN, 32'h0);
    bus(1'b0, `OFS_MON_EN, 32'h0);
    chk("locked enable", 32'h0000_07FF, rdData);
    bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY);
    bus(1'b1, `OFS_MON_EN, 32'h0000_07F0);
    bus(1'b0, `OFS_MON_EN, 32'h0);
    chk("unlocked enable", 32'h0000_07F0, rdData);
    bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY);
    bus(1'b1, `OFS_MON_EN, 32'h0000_07FF);
    bus(1'b1, `OFS_CTRL, 32'h0000_0002);
    repeat (SETTLE + 5) @(posedge core_clk);
    // Interrupt: raise from sticky bit, clear, mask, raise again
    bus(1'b1, `OFS_IRQ_EN, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    chk("irq raised", 32'h1, 32'(irq));
    bus(1'b1, `OFS_IRQ_CLR, 32'hFFFF_FFFF);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    trip(1'b1, 8, 7, 12, 1'b0);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("event sticky", 32'h0008_0000, rdData);
    trip(1'b0, 1, 17, 22, 1'b0);
    chk("irq enabled", 32'h1, 32'(irq));
    bus(1'b1, `OFS_IRQ_CLR, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    chk("irq final", 32'h0, 32'(irq));
    // Byte lanes: no lane writes nothing, a partial key does not arm
    wb_sel_i <= 4'h0;
    bus(1'b1, `OFS_CTRL, 32'h0000_001F);
    wb_sel_i <= 4'h7;
    bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY);
    wb_sel_i <= 4'hF;
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl no lanes", 32'h0000_0002, rdData);
    bus(1'b0, `OFS_UNLOCK, 32'h0);
    chk("partial key", 32'h0, rdData);
    // Second reset loads fresh codes and restores defaults
    nvSwUv <= ~SW_UV;
    nvLnUv <= ~LN_UV;
    nvSwOv <= ~SW_OV;
    nvLnOv <= ~LN_OV;
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("uv codes again", 32'({~LN_UV, ~SW_UV}), 32'({lnUvOut, swUvOut}));
    chk("ov codes again", 32'({~LN_OV, ~SW_OV}), 32'({lnOvOut, swOvOut}));
    chk("status after reset", 32'h0, 32'({ovStat, uvStat}));
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl reset again", 32'h0000_0002, rdData);
    tally_and_finish();
  end
endmodule // tb_top
